// ==== inc/serial_status_consts.svh ====
// register offsets, field positions and reset values of the channel status block
// included by the core and the checker; definitions only
`ifndef SERIAL_STATUS_CONSTS_SVH
`define SERIAL_STATUS_CONSTS_SVH

`define OFS_CLEAR_TRIGGER 4'h0
`define OFS_STATUS 4'h2
`define OFS_DATA 4'h4
`define OFS_START 4'h6
`define OFS_STOP 4'h8
`define OFS_RUN_CONFIG 4'hA

`define BIT_OVERRUN 0
`define BIT_PARITY 1
`define BIT_FRAME 2
`define BIT_BUFFER_FULL 5
`define BIT_COMM_ACTIVE 6
`define BIT_RX_ENABLE 14
`define BIT_TX_ENABLE 15

`define RESET_WORD 16'h0000

`endif

// ==== inc/serial_status_pkg.sv ====
// types shared by the channel status block
// assumes the constants header sits beside it
package serial_status_pkg;
    typedef logic [15:0] word_t;
    typedef logic [3:0] addr_t;
    typedef enum logic [1:0] {
        CH_STOPPED = 2'b00,
        CH_STANDBY = 2'b01,
        CH_ACTIVE = 2'b10
    } chan_state_t;
endpackage

// ==== core/serial_channel_status_flags.sv ====
// status and error-flag logic of one serial channel
// assumes a plain register port driven on mclk and a shift engine that raises event pulses
// How it works
// RQ1: writing 1 to a clear bit clears its error flag; 0 leaves it alone
// RQ2: clear bits are pulses and never hold a written value
// RQ3: reading the clear-trigger register always returns zero
// RQ4: clear-trigger register is zero after reset
// RQ5: clear-trigger register accepts full word and low-byte writes
// RQ6: frame clear bit exists only on channel 1; reserved on channel 0
// RQ7: software writes zero to unused upper clear bits
// RQ8: status has active bit 6, full bit 5, frame 2, parity 1, overrun 0
// RQ9: status register is zero after reset
// RQ10: status readable as full word or low byte
// RQ11: frame error flag exists only on channel 1, else reads zero
// RQ12: active flag is 1 during transfer, 0 when stopped or standby
// RQ13: stop or start trigger clears active flag, entering stopped or standby
// RQ14: active flag sets at transfer start and clears at transfer end
// RQ15: full flag shows whether data register holds valid data
// RQ16: transmit write with transmit enabled sets full flag
// RQ17: received word or receive error with receive enabled sets full flag
// RQ18: data write while full discards old data and sets overrun
// RQ19: full flag clears on move to shifter, data read, or stop
// RQ20: missing stop bit sets frame error flag
// RQ21: parity mismatch or missing acknowledge sets parity error flag
// RQ22: unread received word plus new write or word sets overrun
// RQ23: start trigger sets enabled status; stop trigger clears it
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "serial_status_consts.svh"

module serial_channel_status_flags #(
    parameter int CHANNEL = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire serial_status_pkg::addr_t regAddr,
    input wire serial_status_pkg::word_t regWdata,
    input wire logic regWrite,
    input wire logic regByte,
    input wire logic regRead,
    output serial_status_pkg::word_t regRdata,
    // events from the shift engine
    input wire logic xferBegin,
    input wire logic xferEnd,
    input wire logic txLoadShift,
    input wire logic rxStore,
    input wire serial_status_pkg::word_t rxWord,
    input wire logic rxNoStop,
    input wire logic rxParityBad,
    input wire logic ackMissing,
    // state seen by the shift engine
    output serial_status_pkg::word_t dataWord,
    output serial_status_pkg::word_t runConfig,
    output logic channelEnabled,
    output logic commActive,
    output logic bufferFull
);
    import serial_status_pkg::*;

    localparam bit HAS_FRAME = (CHANNEL == 1);

    typedef struct packed {
        word_t rdata;
        word_t clearTrig;
        word_t data;
        word_t runCfg;
        chan_state_t chState;
        logic enabled;
        logic active;
        logic full;
        logic frameErr;
        logic parityErr;
        logic overrunErr;
    } state_t;

    state_t st;
    state_t next_st;

    // merges a write into a register, keeping the upper byte on a byte write
    function automatic word_t merge(input word_t old, input word_t wd, input logic bw);
        merge = bw ? {old[15:8], wd[7:0]} : wd;
    endfunction

    // assembles the status word; bits not listed read zero
    function automatic word_t statusWord(input state_t s);
        word_t w;
        w = `RESET_WORD;
        w[`BIT_COMM_ACTIVE] = s.active; // RQ8
        w[`BIT_BUFFER_FULL] = s.full; // RQ8
        w[`BIT_FRAME] = HAS_FRAME & s.frameErr; // RQ11
        w[`BIT_PARITY] = s.parityErr;
        w[`BIT_OVERRUN] = s.overrunErr;
        statusWord = w;
    endfunction

    logic wrClear;
    logic wrData;
    logic wrStart;
    logic wrStop;
    logic rdData;
    word_t clrIn;
    logic clrFrame;
    logic clrParity;
    logic clrOverrun;

    // decode of the register port
    always_comb begin
        wrClear = regWrite && (regAddr == `OFS_CLEAR_TRIGGER);
        wrData = regWrite && (regAddr == `OFS_DATA);
        wrStart = regWrite && (regAddr == `OFS_START) && regWdata[0];
        wrStop = regWrite && (regAddr == `OFS_STOP) && regWdata[0];
        rdData = regRead && (regAddr == `OFS_DATA);
        // a byte write reaches only the low byte, where all clear bits live
        clrIn = wrClear ? merge(`RESET_WORD, regWdata, regByte) : `RESET_WORD; // RQ5
        clrFrame = HAS_FRAME & clrIn[`BIT_FRAME]; // RQ6
        clrParity = clrIn[`BIT_PARITY]; // RQ1
        clrOverrun = clrIn[`BIT_OVERRUN]; // RQ1
    end

    // next-state of the whole block
    always_comb begin
        next_st = st;
        // trigger bits live one cycle: the flag clears on that edge, then they drop
        next_st.clearTrig = `RESET_WORD; // RQ2
        next_st.clearTrig[`BIT_FRAME] = clrFrame; // RQ6
        next_st.clearTrig[`BIT_PARITY] = clrParity;
        next_st.clearTrig[`BIT_OVERRUN] = clrOverrun;

        if (regWrite && regAddr == `OFS_RUN_CONFIG) begin
            next_st.runCfg = merge(st.runCfg, regWdata, regByte);
        end

        // error flags: a set in the cycle of a clear wins, so no event is lost
        if (clrFrame) begin
            next_st.frameErr = 1'b0; // RQ1
        end
        if (clrParity) begin
            next_st.parityErr = 1'b0; // RQ1
        end
        if (clrOverrun) begin
            next_st.overrunErr = 1'b0; // RQ1
        end
        if (HAS_FRAME && rxNoStop) begin
            next_st.frameErr = 1'b1; // RQ20
        end
        if (rxParityBad || ackMissing) begin
            next_st.parityErr = 1'b1; // RQ21
        end

        // data register and buffer-full flag
        if (txLoadShift || rdData) begin
            next_st.full = 1'b0; // RQ19
        end
        if (rxStore && st.runCfg[`BIT_RX_ENABLE]) begin
            next_st.data = rxWord;
            next_st.full = 1'b1; // RQ17
            if (st.full) begin
                next_st.overrunErr = 1'b1; // RQ22
            end
        end
        if ((rxNoStop || rxParityBad) && st.runCfg[`BIT_RX_ENABLE]) begin
            next_st.full = 1'b1; // RQ17
        end
        if (wrData) begin
            // old contents are simply overwritten, which is the discard
            next_st.data = merge(st.data, regWdata, regByte);
            if (st.full) begin
                next_st.overrunErr = 1'b1; // RQ18
            end
            if (st.runCfg[`BIT_TX_ENABLE]) begin
                next_st.full = 1'b1; // RQ16
            end
        end

        // channel state: transfers move to active, triggers take it back out
        case (st.chState)
            CH_STOPPED: begin
                if (wrStart) begin
                    next_st.chState = CH_STANDBY;
                end
            end
            CH_STANDBY: begin
                if (xferBegin && !wrStop && !wrStart) begin
                    next_st.chState = CH_ACTIVE;
                end
            end
            CH_ACTIVE: begin
                if (xferEnd) begin
                    next_st.chState = CH_STANDBY;
                end
            end
            default: begin
                next_st.chState = CH_STOPPED;
            end
        endcase
        if (wrStart && st.chState != CH_STOPPED) begin
            next_st.chState = CH_STANDBY; // RQ13
        end
        if (wrStop) begin
            next_st.chState = CH_STOPPED; // RQ13
            next_st.full = 1'b0; // RQ19
        end
        if (wrStart) begin
            next_st.enabled = 1'b1; // RQ23
        end
        if (wrStop) begin
            next_st.enabled = 1'b0; // RQ23
        end
        next_st.active = (next_st.chState == CH_ACTIVE); // RQ12 RQ14

        // read data stands only in the cycle after the strobe
        next_st.rdata = `RESET_WORD;
        if (regRead) begin
            case (regAddr)
                `OFS_STATUS: next_st.rdata = statusWord(st); // RQ10
                `OFS_DATA: next_st.rdata = st.data;
                `OFS_RUN_CONFIG: next_st.rdata = st.runCfg;
                // the trigger, start and stop registers read as zero
                `OFS_CLEAR_TRIGGER: next_st.rdata = `RESET_WORD; // RQ3
                default: next_st.rdata = `RESET_WORD;
            endcase
        end
    end

    // all state in one register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0; // RQ4 RQ9
        end else begin
            st <= next_st;
        end
    end

    assign regRdata = st.rdata;
    assign dataWord = st.data;
    assign runConfig = st.runCfg;
    assign channelEnabled = st.enabled;
    assign commActive = st.active;
    assign bufferFull = st.full; // RQ15
endmodule

// ==== test/serial_status_asserts.sv ====
// timing checker for the channel status block, bound to every instance
// assumes one mclk domain and single-cycle register strobes and event pulses
`timescale 1ns/1ps
`include "serial_status_consts.svh"
module serial_status_asserts #(
    parameter int CHANNEL = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire serial_status_pkg::addr_t regAddr,
    input wire serial_status_pkg::word_t regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire serial_status_pkg::word_t regRdata,
    // events
    input wire logic xferBegin,
    input wire logic xferEnd,
    input wire logic txLoadShift,
    input wire logic rxStore,
    // state
    input wire serial_status_pkg::word_t runConfig,
    input wire logic channelEnabled,
    input wire logic commActive,
    input wire logic bufferFull
);
    import serial_status_pkg::*;
    // bits that must read zero; the frame bit is absent on channel 0
    localparam word_t ZMASK = (CHANNEL == 1) ? 16'hFF98 : 16'hFF9C;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // trigger writes; only bit 0 matters
    sequence start_wr;
        regWrite && regAddr == `OFS_START && regWdata[0];
    endsequence
    sequence stop_wr;
        regWrite && regAddr == `OFS_STOP && regWdata[0];
    endsequence
    chk_clear_reads_zero: assert property (regRead && regAddr == `OFS_CLEAR_TRIGGER
        |=> regRdata == 16'h0000) else $error("clear trigger read not zero");
    chk_status_layout: assert property (regRead && regAddr == `OFS_STATUS |=>
        (regRdata & ZMASK) == 16'h0000 && regRdata[6:5] == {$past(commActive),
        $past(bufferFull)}) else $error("status word layout wrong");
    chk_tx_sets_full: assert property (regWrite && regAddr == `OFS_DATA && runConfig[15]
        |=> bufferFull) else $error("transmit write left full clear");
    chk_rx_sets_full: assert property (rxStore && runConfig[14] && !txLoadShift
        && !regRead |=> bufferFull) else $error("stored word left full clear");
    chk_load_clears_full: assert property (txLoadShift && !rxStore && !regWrite
        |=> !bufferFull) else $error("shift load left full set");
    chk_begin_active: assert property (xferBegin && !xferEnd && channelEnabled
        && !regWrite |=> commActive) else $error("transfer start not flagged");
    chk_end_idle: assert property (xferEnd && !xferBegin |=> !commActive)
        else $error("transfer end left active set");
    chk_start_standby: assert property (start_wr |=> channelEnabled && !commActive)
        else $error("start trigger did not give standby");
    chk_stop_stopped: assert property (stop_wr |=> !channelEnabled && !commActive
        && !bufferFull) else $error("stop trigger did not stop");
    chk_active_enabled: assert property (commActive |-> channelEnabled)
        else $error("active while stopped");
endmodule
bind serial_channel_status_flags serial_status_asserts #(.CHANNEL(CHANNEL)) chk (.mclk, .rst,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .xferBegin, .xferEnd, .txLoadShift,
    .rxStore, .runConfig, .channelEnabled, .commActive, .bufferFull);

// ==== test/tb_serial_channel_status_flags.sv ====
// self-checking bench for the channel status block, channel 1 and channel 0 side by side
// assumes the core, its package and the checker are compiled before it
`timescale 1ns/1ps
module tb_serial_channel_status_flags;
    import serial_status_pkg::*;
    localparam logic [1:0] WR = 2'h0, RD = 2'h1, EV = 2'h2, BW = 2'h3;
    typedef struct packed {logic [1:0] k; addr_t a; word_t d; word_t e;} row_t;
    logic mclk = 1'b0, rst = 1'b1, regWrite = 1'b0, regByte = 1'b0, regRead = 1'b0;
    logic [6:0] ev = 7'h00;
    wire logic ackMissing, rxNoStop, rxParityBad, rxStore, txLoadShift, xferEnd, xferBegin;
    logic channelEnabled, commActive, bufferFull;
    addr_t regAddr = 4'h0;
    word_t regWdata = 16'h0000, rxWord = 16'h00A5, regRdata, rd0, dataWord, runConfig;
    int miscompares = 0, checks = 0;
    // event pulses packed so one row can raise several at once
    assign {ackMissing, rxNoStop, rxParityBad, rxStore, txLoadShift, xferEnd, xferBegin} = ev;
    // kind, offset, write data or pulses, expected read
    row_t rows[$] = '{
        '{RD, 4'h2, 16'h0000, 16'h0000},
        '{RD, 4'h0, 16'h0000, 16'h0000},
        '{WR, 4'hA, 16'hC000, 16'h0000},
        '{WR, 4'h6, 16'h0001, 16'h0000},
        '{EV, 4'h0, 16'h0001, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0040},
        '{WR, 4'h6, 16'h0001, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0000},
        '{EV, 4'h0, 16'h0008, 16'h0000},
        '{EV, 4'h0, 16'h0008, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0021},
        '{RD, 4'h4, 16'h0000, 16'h00A5},
        '{RD, 4'h2, 16'h0000, 16'h0001},
        '{EV, 4'h0, 16'h0030, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0027},
        '{WR, 4'h0, 16'h0000, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0027},
        '{BW, 4'h0, 16'h0002, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0025},
        '{WR, 4'h0, 16'h0001, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0024},
        '{EV, 4'h0, 16'h0044, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0006},
        '{WR, 4'h4, 16'h1234, 16'h0000},
        '{WR, 4'h4, 16'h5678, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0027},
        '{RD, 4'h4, 16'h0000, 16'h5678},
        '{EV, 4'h0, 16'h0001, 16'h0000},
        '{EV, 4'h0, 16'h0002, 16'h0000},
        '{RD, 4'h2, 16'h0000, 16'h0007},
        '{WR, 4'h8, 16'h0001, 16'h0000},
        '{RD, 4'hE, 16'h0000, 16'h0000}
    };
    serial_channel_status_flags uut (.*);
    serial_channel_status_flags #(.CHANNEL(0)) uut0 (.*, .regRdata(rd0), .dataWord(),
        .runConfig(), .channelEnabled(), .commActive(), .bufferFull());
    // 200 MHz clock
    initial forever #2.5 mclk = ~mclk;
    task automatic cmp(input word_t got, input word_t exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one strobe or pulse cycle; read data is only valid in the cycle after the strobe
    task automatic op(input row_t r);
        @(posedge mclk);
        regAddr <= r.a;
        regWdata <= r.d;
        regWrite <= (r.k == WR || r.k == BW);
        regByte <= (r.k == BW);
        regRead <= (r.k == RD);
        ev <= (r.k == EV) ? r.d[6:0] : 7'h00;
        @(posedge mclk);
        {regWrite, regByte, regRead} <= 3'b000;
        ev <= 7'h00;
        #1;
        if (r.k == RD) begin
            cmp(regRdata, r.e);
            cmp(rd0, r.e & ((r.a == 4'h2) ? 16'hFFFB : 16'hFFFF));
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i])
            op(rows[i]);
        // the level outputs after the closing stop; nothing above looks at them directly
        cmp({13'h0000, channelEnabled, commActive, bufferFull}, 16'h0000);
        cmp(runConfig, 16'hC000);
        cmp(dataWord, 16'h5678);
        // reset again while error flags stand
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        op('{RD, 4'h2, 16'h0000, 16'h0000});
        op('{RD, 4'h0, 16'h0000, 16'h0000});
        finish_test;
    end
    // watchdog far beyond the roughly 90 cycles the whole run needs
    initial begin
        #20000;
        miscompares++;
        finish_test;
    end
endmodule
